// ### bht_pkg.sv
/*
 * Constants and carrier types for the branch history table control block.
 * Assumes a single core clock and a synchronous active-high core reset.
 */
package bht_pkg;

  // register port address
  localparam logic [15:0] BPC_ADDR = 16'h00d4;

  // field positions of branch_predict_control
  localparam int VEC_LSB = 16;
  localparam int VEC_MSB = 31;
  localparam int LOAD_BIT = 8;
  localparam int CLR_BIT = 7;
  localparam int FLUSH_BIT = 6;
  localparam int MISP_BIT = 5;
  localparam int HIST_W = 4;
  localparam int CNT_W = 9;
  localparam int VEC_W = 16;

  // table size and reset values
  localparam int TABLE_DEPTH = 512;
  localparam logic [3:0] HIST_NEUTRAL = 4'h4;
  localparam logic [15:0] VEC_RESET = 16'h0000;

  // processor register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bht_req_t;

  // branch resolution from the pipeline
  typedef struct packed {
    logic valid;
    logic [8:0] index;
    logic taken;
  } bht_res_t;

  // prediction lookup from the pipeline
  typedef struct packed {
    logic valid;
    logic [8:0] index;
  } bht_look_t;

endpackage : bht_pkg

// ### bht_ctrl.sv
/*
 * Branch history table with its control register and diagnostic access.
 * Assumes the register port and the pipeline run on the core clock,
 * so no input is synchronised; one request per cycle on each port.
 */
`timescale 1ns/1ps
`default_nettype none

module bht_ctrl #(
  parameter int DEPTH = bht_pkg::TABLE_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // processor register port
  input wire bht_pkg::bht_req_t req_i,
  output logic rvalid_q,
  output logic [31:0] rdata_q,
  // pipeline lookup and resolution
  input wire bht_pkg::bht_look_t look_i,
  input wire bht_pkg::bht_res_t res_i,
  input wire logic ctx_flush_i,
  output logic pvalid_q,
  output logic ptaken_q,
  output logic misp_q
);

  // stored state
  logic [bht_pkg::VEC_W-1:0] vec_q; // prediction vector
  logic [bht_pkg::CNT_W-1:0] cnt_q; // table index counter
  logic [bht_pkg::CNT_W-1:0] cnt_d; // next counter
  logic [bht_pkg::HIST_W-1:0] table_q [DEPTH]; // history entries

  // decode of the register port
  wire sel = (req_i.addr == bht_pkg::BPC_ADDR);
  wire wr_hit = req_i.wr & sel;
  // a write in the same cycle takes the port; the read is dropped
  wire rd_hit = req_i.rd & sel & ~req_i.wr;
  wire load_cmd = wr_hit & req_i.wdata[bht_pkg::LOAD_BIT];
  wire clr_cmd = wr_hit & req_i.wdata[bht_pkg::CLR_BIT];
  wire flush_cmd = wr_hit & req_i.wdata[bht_pkg::FLUSH_BIT];
  wire table_flush = flush_cmd | ctx_flush_i;
  wire [2:0] code = req_i.wdata[bht_pkg::LOAD_BIT:bht_pkg::FLUSH_BIT];

  // counter step and selected entry
  wire [bht_pkg::CNT_W-1:0] cnt_inc = cnt_q + 9'h001;
  wire [bht_pkg::HIST_W-1:0] cur_hist = table_q[cnt_q];
  wire [bht_pkg::HIST_W-1:0] new_hist = req_i.wdata[bht_pkg::HIST_W-1:0];

  // predictions from the vector indexed by history
  wire [bht_pkg::HIST_W-1:0] look_hist = table_q[look_i.index];
  wire [bht_pkg::HIST_W-1:0] res_hist = table_q[res_i.index];
  wire look_pred = vec_q[look_hist];
  wire res_pred = vec_q[res_hist];
  wire res_wrong = res_pred ^ res_i.taken;

  // read word: commands never read back, only live state
  wire [31:0] rdata_d = {vec_q, 7'h00, 3'h0, misp_q, 1'b0, cur_hist};

  // counter next value: clear beats step; old value indexes the write
  always_comb begin
    if (clr_cmd) begin
      cnt_d = '0;
    end else if (load_cmd | rd_hit) begin
      cnt_d = cnt_inc;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // vector and counter registers
  always_ff @(posedge clock) begin
    if (rst) begin
      vec_q <= bht_pkg::VEC_RESET;
      cnt_q <= '0;
    end else begin
      if (wr_hit) begin
        vec_q <= req_i.wdata[bht_pkg::VEC_MSB:bht_pkg::VEC_LSB];
      end
      cnt_q <= cnt_d;
    end
  end

  // history entries: software write, then flush, then pipeline shift
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    wire hit_sw = load_cmd & (cnt_q == bht_pkg::CNT_W'(g));
    wire hit_res = res_i.valid & (res_i.index == bht_pkg::CNT_W'(g));
    always_ff @(posedge clock) begin
      if (rst) begin
        table_q[g] <= bht_pkg::HIST_NEUTRAL;
      end else if (hit_sw) begin
        table_q[g] <= new_hist;
      end else if (table_flush) begin
        table_q[g] <= bht_pkg::HIST_NEUTRAL;
      end else if (hit_res) begin
        table_q[g] <= {table_q[g][2:0], res_i.taken};
      end
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rvalid_q <= rd_hit;
      if (rd_hit) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // pipeline answers and mispredict flag
  always_ff @(posedge clock) begin
    if (rst) begin
      pvalid_q <= 1'b0;
      ptaken_q <= 1'b0;
      misp_q <= 1'b0;
    end else begin
      pvalid_q <= look_i.valid;
      if (look_i.valid) begin
        ptaken_q <= look_pred;
      end
      if (res_i.valid) begin
        misp_q <= res_wrong;
      end
    end
  end

  // checks
  sequence s_read;
    rd_hit;
  endsequence

  sequence s_read_twice;
    rd_hit ##1 rd_hit;
  endsequence

  property p_vec_load;
    @(posedge clock) disable iff (rst)
      wr_hit |=> vec_q == $past(req_i.wdata[31:16]);
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector not loaded by write");

  property p_rd_vec;
    @(posedge clock) disable iff (rst)
      s_read |=> rvalid_q && rdata_q[31:16] == $past(vec_q);
  endproperty
  a_rd_vec: assert property (p_rd_vec) else $error("read vector wrong");

  property p_rd_hist;
    @(posedge clock) disable iff (rst)
      s_read |=> rdata_q[3:0] == $past(cur_hist) && rdata_q[8:6] == 3'h0;
  endproperty
  a_rd_hist: assert property (p_rd_hist) else $error("read history or command bits wrong");

  property p_flush;
    @(posedge clock) disable iff (rst)
      table_flush && !(load_cmd && cnt_q == 9'h000) |=> table_q[0] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left entry non neutral");

  property p_ctx;
    @(posedge clock) disable iff (rst)
      ctx_flush_i && !wr_hit |=> table_q[DEPTH-1] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_ctx: assert property (p_ctx) else $error("context flush missed");

  property p_clr;
    @(posedge clock) disable iff (rst)
      clr_cmd |=> cnt_q == 9'h000;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared");

  property p_step;
    @(posedge clock) disable iff (rst)
      s_read_twice |=> cnt_q == $past(cnt_q, 2) + 9'h002;
  endproperty
  a_step: assert property (p_step) else $error("reads do not step counter");

  property p_load;
    @(posedge clock) disable iff (rst)
      load_cmd && !clr_cmd |=> cnt_q == $past(cnt_inc);
  endproperty
  a_load: assert property (p_load) else $error("history write did not increment");

  property p_code0;
    @(posedge clock) disable iff (rst)
      wr_hit && code == 3'h0 |=> cnt_q == $past(cnt_q);
  endproperty
  a_code0: assert property (p_code0) else $error("plain write moved counter");

  property p_misp;
    @(posedge clock) disable iff (rst)
      res_i.valid |=> misp_q == ($past(res_pred) != $past(res_i.taken));
  endproperty
  a_misp: assert property (p_misp) else $error("mispredict flag wrong");

  // request kinds used by the checks below
  sequence s_wr_code(logic [2:0] c);
    wr_hit && code == c;
  endsequence

  sequence s_lookup;
    look_i.valid;
  endsequence

  // reset leaves counter, vector, flag and entries at rest
  property p_reset;
    @(posedge clock)
      rst |=> cnt_q == 9'h000 && vec_q == bht_pkg::VEC_RESET && !misp_q
        && table_q[0] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  // read answer: only after a taken read, data held otherwise
  property p_rvalid_idle;
    @(posedge clock) disable iff (rst)
      !rd_hit |=> !rvalid_q;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");

  property p_rd_drop;
    @(posedge clock) disable iff (rst)
      req_i.rd && wr_hit |=> !rvalid_q;
  endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read beside write answered");

  property p_rdata_hold;
    @(posedge clock) disable iff (rst)
      !rd_hit |=> $stable(rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_rd_misp;
    @(posedge clock) disable iff (rst)
      s_read |=> rdata_q[bht_pkg::MISP_BIT] == $past(misp_q);
  endproperty
  a_rd_misp: assert property (p_rd_misp) else $error("read flag bit wrong");

  property p_rd_zero;
    @(posedge clock) disable iff (rst)
      s_read |=> rdata_q[15:9] == 7'h00 && rdata_q[4] == 1'b0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unused read bits set");

  // a read leaves the entry it returns untouched
  property p_rd_keep;
    @(posedge clock) disable iff (rst)
      rd_hit && !ctx_flush_i && !res_i.valid |=> table_q[$past(cnt_q)] == $past(cur_hist);
  endproperty
  a_rd_keep: assert property (p_rd_keep) else $error("read changed entry");

  // software history write and the write-action codes
  property p_hist_wr;
    @(posedge clock) disable iff (rst)
      load_cmd |=> table_q[$past(cnt_q)] == $past(new_hist);
  endproperty
  a_hist_wr: assert property (p_hist_wr) else $error("history not stored");

  property p_code1;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h1) |=> cnt_q == $past(cnt_q)
        && table_q[$past(cnt_q)] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_code1: assert property (p_code1) else $error("code 1 effect wrong");

  property p_code2;
    @(posedge clock) disable iff (rst)
      wr_hit && code == 3'h2 && !res_i.valid && !ctx_flush_i |=> cnt_q == 9'h000
        && table_q[$past(cnt_q)] == $past(cur_hist);
  endproperty
  a_code2: assert property (p_code2) else $error("code 2 effect wrong");

  property p_code3;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h3) |=> cnt_q == 9'h000
        && table_q[$past(cnt_q)] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_code3: assert property (p_code3) else $error("code 3 effect wrong");

  property p_code4;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h4) |=> cnt_q == $past(cnt_q) + 9'h001
        && table_q[$past(cnt_q)] == $past(new_hist);
  endproperty
  a_code4: assert property (p_code4) else $error("code 4 effect wrong");

  property p_code5;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h5) |=> cnt_q == $past(cnt_q) + 9'h001
        && table_q[$past(cnt_q)] == $past(new_hist) && table_q[cnt_q] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_code5: assert property (p_code5) else $error("code 5 effect wrong");

  property p_code6;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h6) |=> cnt_q == 9'h000 && table_q[$past(cnt_q)] == $past(new_hist);
  endproperty
  a_code6: assert property (p_code6) else $error("code 6 effect wrong");

  property p_code7;
    @(posedge clock) disable iff (rst)
      s_wr_code(3'h7) |=> cnt_q == 9'h000 && table_q[$past(cnt_q)] == $past(new_hist)
        && table_q[$past(cnt_q) + 9'h001] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_code7: assert property (p_code7) else $error("code 7 effect wrong");

  // pipeline answers: valid one cycle after the request, prediction and flag held otherwise
  property p_look;
    @(posedge clock) disable iff (rst)
      s_lookup |=> pvalid_q && ptaken_q == $past(vec_q[table_q[look_i.index]]);
  endproperty
  a_look: assert property (p_look) else $error("prediction wrong");

  property p_pvalid_idle;
    @(posedge clock) disable iff (rst)
      !look_i.valid |=> !pvalid_q;
  endproperty
  a_pvalid_idle: assert property (p_pvalid_idle) else $error("prediction without lookup");

  property p_ptaken_hold;
    @(posedge clock) disable iff (rst)
      !look_i.valid |=> $stable(ptaken_q);
  endproperty
  a_ptaken_hold: assert property (p_ptaken_hold) else $error("prediction moved");

  property p_misp_hold;
    @(posedge clock) disable iff (rst)
      !res_i.valid |=> $stable(misp_q);
  endproperty
  a_misp_hold: assert property (p_misp_hold) else $error("flag moved without branch");

  // resolution shifts the outcome into its entry when nothing overrides it
  property p_shift;
    @(posedge clock) disable iff (rst)
      res_i.valid && !table_flush && !load_cmd |=> table_q[$past(res_i.index)]
        == {$past(res_hist[2:0]), $past(res_i.taken)};
  endproperty
  a_shift: assert property (p_shift) else $error("history not shifted");

  // a context flush leaves the counter alone and neutralises the entries
  property p_ctx_keep;
    @(posedge clock) disable iff (rst)
      ctx_flush_i && !wr_hit && !rd_hit |=> cnt_q == $past(cnt_q)
        && table_q[$past(cnt_q)] == bht_pkg::HIST_NEUTRAL;
  endproperty
  a_ctx_keep: assert property (p_ctx_keep) else $error("context flush wrong");

endmodule : bht_ctrl

`default_nettype wire

// ### bht_pipe_model.sv
/* pipeline partner: one-cycle lookup, resolution and flush pulses.
   assumes the core clock; the bench asks for one operation at a time. */
`timescale 1ns/1ps
`default_nettype none
module bht_pipe_model (
  // clock
  input wire logic clock,
  // request: 1 lookup, 2 resolve, 3 flush
  input wire logic [1:0] op,
  input wire logic [8:0] idx,
  input wire logic tkn,
  // towards the table
  output var bht_pkg::bht_look_t look_o,
  output var bht_pkg::bht_res_t res_o,
  output var logic ctx_o
);
  logic [8:0] junk_q = 9'h155; // idle pattern, flips every cycle
  // pulse just after the edge; idle fields never hold a stale value
  always @(posedge clock) begin
    junk_q <= ~junk_q;
    look_o <= #1 {op == 2'h1, (op == 2'h1) ? idx : junk_q};
    res_o <= #1 {op == 2'h2, (op == 2'h2) ? idx : junk_q, (op == 2'h2) ? tkn : junk_q[0]};
    ctx_o <= #1 (op == 2'h3);
  end
endmodule : bht_pipe_model
`default_nettype wire

// ### test_branch_history_table_ctrl.sv
/* self-checking bench for the branch history table control block.
   assumes bht_pkg, bht_ctrl and the pipeline partner are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_branch_history_table_ctrl;
  logic clock = 1'b0; // core clock
  logic rst = 1'b1; // synchronous reset
  bht_pkg::bht_req_t req = '0; // register port
  bht_pkg::bht_look_t look;
  bht_pkg::bht_res_t res;
  logic ctx, rvalid_q, pvalid_q, ptaken_q, misp_q;
  logic [31:0] rdata_q;
  logic [1:0] op = 2'h0; // partner request
  logic [8:0] idx = 9'h0;
  logic tkn = 1'b0;
  // reference state
  logic [3:0] tbl [512];
  logic [15:0] vec = 16'h0;
  logic [8:0] cnt = 9'h0;
  logic misp = 1'b0;
  logic [31:0] lf = 32'h61; // random source
  logic [31:0] d;
  int num_errors = 0;
  int check_count = 0;
  // clock
  initial forever #5 clock = ~clock;
  bht_ctrl i_dut (.clock(clock), .rst(rst), .req_i(req), .rvalid_q(rvalid_q),
    .rdata_q(rdata_q), .look_i(look), .res_i(res), .ctx_flush_i(ctx),
    .pvalid_q(pvalid_q), .ptaken_q(ptaken_q), .misp_q(misp_q));
  bht_pipe_model i_pipe (.clock(clock), .op(op), .idx(idx), .tkn(tkn),
    .look_o(look), .res_o(res), .ctx_o(ctx));
  // linear feedback shift register
  function logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // verdict
  task results();
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // register write, then the same effect on the reference
  task wr(input logic [31:0] w, input logic r);
    @(posedge clock);
    #1 req = {r, 1'b1, bht_pkg::BPC_ADDR, w};
    @(posedge clock);
    #1 {req.rd, req.wr} = 2'b00;
    chk(rvalid_q, 1'b0);
    vec = w[31:16];
    if (w[6]) foreach (tbl[i]) tbl[i] = bht_pkg::HIST_NEUTRAL;
    if (w[8]) tbl[cnt] = w[3:0];
    cnt = w[7] ? 9'h0 : cnt + w[8];
  endtask : wr
  // register read held for n edges, each answered one cycle after it is taken
  task rd(input logic [15:0] a, input int n);
    @(posedge clock);
    #1 req = {1'b1, 1'b0, a, lf};
    repeat (n) begin
      @(posedge clock);
      #1 chk(rvalid_q, a == bht_pkg::BPC_ADDR);
      if (a == bht_pkg::BPC_ADDR) begin
        chk(rdata_q, {vec, 10'h0, misp, 1'b0, tbl[cnt]});
        cnt++;
      end
    end
    req.rd = 1'b0;
  endtask : rd
  // one pipeline operation through the partner
  task pipe(input logic [1:0] o, input logic [8:0] i, input logic t);
    @(posedge clock);
    #1 {op, idx, tkn} = {o, i, t};
    @(posedge clock);
    #1 op = 2'h0;
    @(posedge clock);
    #1;
    if (o == 2'h1) chk({pvalid_q, ptaken_q}, {1'b1, vec[tbl[i]]});
    if (o == 2'h2) begin
      misp = vec[tbl[i]] != t;
      tbl[i] = {tbl[i][2:0], t};
      chk(misp_q, misp);
    end
    if (o == 2'h3) foreach (tbl[n]) tbl[n] = bht_pkg::HIST_NEUTRAL;
  endtask : pipe
  // main sequence
  initial begin
    foreach (tbl[i]) tbl[i] = bht_pkg::HIST_NEUTRAL;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    rd(bht_pkg::BPC_ADDR, 1); // reset values
    rd(16'h00d5, 1); // unmapped address gives no answer
    for (int k = 0; k < 96; k++) begin
      d = rnd();
      d[8:6] = k[2:0]; // every write code in turn
      wr(d, k[3]); // half the writes carry a read that must be dropped
      rd(bht_pkg::BPC_ADDR, 1);
      d = rnd();
      pipe(2'(k % 3 + 1), {7'h0, d[1:0]}, d[2]);
      rd(bht_pkg::BPC_ADDR, 2); // back to back reads step the counter
    end
    results();
  end
endmodule : test_branch_history_table_ctrl
`default_nettype wire
